// ### core/acc_ctrl.sv
// conversion control top: register file on AXI4-Lite, flags, interrupt, pin control
//
// Functional notes
// R1: with compare off, every finished conversion sets the done flag, status bit 7.
// R2: with compare on, a finished conversion sets the flag only if compare holds.
// R3: writing status/control or reading the result low byte clears the done flag.
// R4: done flag setting while interrupt enable bit 6 is high raises the interrupt; the code also needs irq_mask bit 0 set.
// R5: continuous bit 5 clear: one conversion per write or per hardware trigger.
// R6: continuous bit 5 set: back-to-back conversions after a write or trigger.
// R7: channel select is a five-bit field in status/control bits 4 to 0.
// R8: codes 0-7 pick inputs 0-7, codes 16-23 pick inputs 16-23.
// R9: all-ones channel code powers the converter off and isolates the input.
// R10: stopping continuous mode with all-ones code runs no extra conversion.
// R11: without continuous mode the converter drops to low power after each conversion.
// R12: two-bit clock source: bus, bus halved, alternate, internal asynchronous.
// R13: pin control register disables digital port control of analog pins 0-7.
// R14: pin control bit n at one disables port control of pin n, zero keeps it.
// R15: a status/control write during a conversion aborts it and starts afresh.
// R16: pin control bits reset to zero so all pins keep port control.
`timescale 1ns/1ps
`include "acc_map.svh"

module acc_ctrl #(
    parameter int ADDR_W = 8,
    parameter int RES_W  = 10
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic              ce,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // converter core side
    input  wire logic              hw_conversion_trigger,
    input  wire logic              conv_done,
    input  wire logic [RES_W-1:0]  conv_data,
    output logic                   conv_start,
    output logic                   conv_abort,
    output logic                   conv_power,
    output logic [4:0]             channel_select,
    output logic                   channel_valid,
    output logic                   channel_isolate,
    output logic [1:0]             conv_clock_source_select,
    output logic [7:0]             analog_pin_disable_n,
    output logic                   irq
);

    // ----
    // parameter checks
    // ----
    generate
        if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
            $error("acc_ctrl: ADDR_W must lie in 5..32");
        end
        if (RES_W < 9 || RES_W > 16) begin : g_bad_res
            $error("acc_ctrl: RES_W must lie in 9..16");
        end
    endgenerate

    // ----
    // state
    // ----
    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic              aw_hold;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_hold;
        logic [7:0]        w_data;
        logic              w_lane0;
        logic              ien;
        logic              cont;
        logic [4:0]        chan;
        logic              done;
        logic [1:0]        clk_sel;
        logic              hw_mode;
        logic              cfe;
        logic              cgt;
        logic [RES_W-1:0]  cmpv;
        logic [RES_W-1:0]  result;
        logic [7:0]        pin;
        logic [1:0]        irq_st;
        logic [1:0]        irq_mask;
        logic              irq;
        logic              chan_ok;
        logic              isolate;
    } acc_state_t;

    acc_state_t       s;
    acc_state_t       n;
    logic             sc_write;
    logic             done_ok;
    logic             cmp_true;
    logic             set_done;
    logic             clr_done;
    logic             resl_read;
    logic             wr_fire;
    logic             wr_map;
    logic             rd_map;
    logic [1:0]       w1c;
    logic [7:0]       wd;
    logic [31:0]      rd_val;
    logic [ADDR_W-1:0] ar_a;

    // byte offset to the block's own address width
    function automatic logic [ADDR_W-1:0] ofs(input logic [7:0] o);
        ofs = ADDR_W'(o);
    endfunction

    // inputs 0-7 and 16-23 exist, other codes select nothing
    function automatic logic chan_exists(input logic [4:0] ch);
        chan_exists = (ch[4:3] == 2'b00) | (ch[4:3] == 2'b10);
    endfunction

    // ----
    // conversion sequencer
    // ----
    acc_conv_seq u_seq (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .ce         (ce),
        .sc_write   (sc_write),
        .hw_mode    (n.hw_mode),
        .cont       (n.cont),
        .chan_code  (n.chan),
        .hw_trigger (hw_conversion_trigger),
        .conv_done  (conv_done),
        .conv_start (conv_start),
        .conv_abort (conv_abort),
        .conv_power (conv_power),
        .done_ok    (done_ok)
    );

    // ----
    // flag events and compare
    // ----
    // compare result: at-or-above or below the compare value
    assign cmp_true = s.cgt ? (conv_data >= s.cmpv) : (conv_data < s.cmpv);
    assign set_done = done_ok & (~s.cfe | cmp_true);               // [R1] [R2]
    assign wr_fire  = s.aw_hold & s.w_hold & ~s.bvalid;
    assign wd       = s.w_lane0 ? s.w_data : 8'h00;
    assign sc_write = wr_fire & s.w_lane0 & (s.aw_addr == ofs(`ACC_OFS_SC));
    assign ar_a     = s_axi_araddr;
    assign resl_read = s_axi_arvalid & s.arready & (ar_a == ofs(`ACC_OFS_RESL));
    assign clr_done = sc_write | resl_read;                         // [R3]

    // ----
    // address decode
    // ----
    always_comb begin
        wr_map = 1'b0;
        rd_map = 1'b1;
        rd_val = 32'h0000_0000;
        case (s.aw_addr)
            ofs(`ACC_OFS_SC), ofs(`ACC_OFS_CFG), ofs(`ACC_OFS_CMPV),
            ofs(`ACC_OFS_PIN), ofs(`ACC_OFS_IRQS), ofs(`ACC_OFS_IRQM): begin
                wr_map = 1'b1;
            end
            ofs(`ACC_OFS_RESH), ofs(`ACC_OFS_RESL): begin
                wr_map = 1'b1;                                      // read-only, write ignored
            end
            default: begin
                wr_map = 1'b0;
            end
        endcase
        case (ar_a)
            ofs(`ACC_OFS_SC): begin
                rd_val = {24'h00_0000, s.done, s.ien, s.cont, s.chan};
            end
            ofs(`ACC_OFS_CFG): begin
                rd_val = {27'h000_0000, s.cgt, s.cfe, s.hw_mode, s.clk_sel};
            end
            ofs(`ACC_OFS_CMPV): begin
                rd_val = 32'(s.cmpv);
            end
            ofs(`ACC_OFS_RESH): begin
                rd_val = 32'(s.result[RES_W-1:8]);
            end
            ofs(`ACC_OFS_RESL): begin
                rd_val = {24'h00_0000, s.result[7:0]};
            end
            ofs(`ACC_OFS_PIN): begin
                rd_val = {24'h00_0000, s.pin};
            end
            ofs(`ACC_OFS_IRQS): begin
                rd_val = {30'h0000_0000, s.irq_st};
            end
            ofs(`ACC_OFS_IRQM): begin
                rd_val = {30'h0000_0000, s.irq_mask};
            end
            default: begin
                rd_map = 1'b0;
            end
        endcase
    end

    // ----
    // next state
    // ----
    always_comb begin
        n   = s;
        w1c = 2'b00;
        // write address and data are taken in either order and held
        if (s_axi_awvalid & s.awready) begin
            n.aw_hold = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid & s.wready) begin
            n.w_hold  = 1'b1;
            n.w_data  = s_axi_wdata[7:0];
            n.w_lane0 = s_axi_wstrb[0];
        end
        if (s.bvalid & s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        // register writes once both halves are in
        if (wr_fire) begin
            n.aw_hold = 1'b0;
            n.w_hold  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = wr_map ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
            if (s.w_lane0) begin
                case (s.aw_addr)
                    ofs(`ACC_OFS_SC): begin
                        n.ien  = wd[`ACC_SC_IEN];
                        n.cont = wd[`ACC_SC_CONT];
                        n.chan = wd[4:0];                           // [R7]
                    end
                    ofs(`ACC_OFS_CFG): begin
                        n.clk_sel = wd[`ACC_CFG_CLK_LSB +: 2];      // [R12]
                        n.hw_mode = wd[`ACC_CFG_HWT];
                        n.cfe     = wd[`ACC_CFG_CFE];
                        n.cgt     = wd[`ACC_CFG_CGT];
                    end
                    ofs(`ACC_OFS_CMPV): begin
                        // only the low byte lane is wired; upper bits keep their value
                        n.cmpv[7:0] = wd;
                    end
                    ofs(`ACC_OFS_PIN): begin
                        n.pin = wd;                                 // [R13] [R14]
                    end
                    ofs(`ACC_OFS_IRQS): begin
                        w1c = wd[1:0];
                    end
                    ofs(`ACC_OFS_IRQM): begin
                        n.irq_mask = wd[1:0];
                    end
                    default: begin
                        n.pin = s.pin;
                    end
                endcase
            end
        end
        // each channel is ready for a new half only while its own half is not held
        n.awready = ~n.aw_hold;
        n.wready  = ~n.w_hold;
        // one read at a time: refuse the address until the data is taken
        if (s.rvalid & s_axi_rready) begin
            n.rvalid  = 1'b0;
            n.arready = 1'b1;
        end
        if (s_axi_arvalid & s.arready) begin
            n.arready = 1'b0;
            n.rvalid  = 1'b1;
            n.rdata   = rd_val;
            n.rresp   = rd_map ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
        end
        // conversion end: result latched, flag set wins over a clear
        if (done_ok) begin
            n.result = conv_data;
        end
        n.done = set_done | (s.done & ~clr_done);                  // [R1] [R2] [R3]
        // sticky status, write one to clear, new events win
        n.irq_st[`ACC_IRQ_DONE] = (set_done & n.ien) |
                                  (s.irq_st[`ACC_IRQ_DONE] & ~w1c[`ACC_IRQ_DONE]); // [R4]
        n.irq_st[`ACC_IRQ_END]  = done_ok |
                                  (s.irq_st[`ACC_IRQ_END] & ~w1c[`ACC_IRQ_END]);
        n.irq     = |(n.irq_st & n.irq_mask);                       // [R4]
        n.chan_ok = chan_exists(n.chan);                            // [R8]
        n.isolate = acc_pkg::acc_chan_off(n.chan);                  // [R9]
    end

    // ----
    // state register
    // ----
    // ce low freezes everything, the bus included
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s          <= '0;
            s.awready  <= 1'b1;
            s.wready   <= 1'b1;
            s.arready  <= 1'b1;
            s.chan     <= `ACC_RST_CHAN;
            s.clk_sel  <= `ACC_RST_CLK;
            s.pin      <= `ACC_RST_PIN;                             // [R16]
            s.irq_mask <= `ACC_RST_IRQM;
            s.isolate  <= 1'b1;
        end else if (ce) begin
            s <= n;
        end
    end

    // ----
    // outputs, each straight from a flip-flop
    // ----
    assign s_axi_awready            = s.awready;
    assign s_axi_wready             = s.wready;
    assign s_axi_bvalid             = s.bvalid;
    assign s_axi_bresp              = s.bresp;
    assign s_axi_arready            = s.arready;
    assign s_axi_rvalid             = s.rvalid;
    assign s_axi_rdata              = s.rdata;
    assign s_axi_rresp              = s.rresp;
    assign channel_select           = s.chan;                       // [R7]
    assign channel_valid            = s.chan_ok;                    // [R8]
    assign channel_isolate          = s.isolate;                    // [R9]
    assign conv_clock_source_select = s.clk_sel;                    // [R12]
    assign analog_pin_disable_n     = s.pin;                        // [R14]
    assign irq                      = s.irq;

endmodule

// ### core/acc_map.svh
// register offsets, field positions and reset values of the conversion control block
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// ----
// register byte offsets
// ----
`define ACC_OFS_SC      8'h00
`define ACC_OFS_CFG     8'h04
`define ACC_OFS_CMPV    8'h08
`define ACC_OFS_RESH    8'h0c
`define ACC_OFS_RESL    8'h10
`define ACC_OFS_PIN     8'h14
`define ACC_OFS_IRQS    8'h18
`define ACC_OFS_IRQM    8'h1c

// ----
// field positions
// ----
`define ACC_SC_DONE     7
`define ACC_SC_IEN      6
`define ACC_SC_CONT     5
`define ACC_CFG_CLK_LSB 0
`define ACC_CFG_HWT     2
`define ACC_CFG_CFE     3
`define ACC_CFG_CGT     4
`define ACC_IRQ_DONE    0
`define ACC_IRQ_END     1

// ----
// codes and reset values
// ----
`define ACC_CHAN_OFF    5'h1f
`define ACC_RST_CHAN    5'h1f
`define ACC_RST_CLK     2'h0
`define ACC_RST_PIN     8'h00
`define ACC_RST_IRQM    2'h0
`define ACC_RESP_OKAY   2'h0
`define ACC_RESP_SLVERR 2'h2

`endif

// ### core/acc_pkg.sv
// shared types and the off-code decode function of the conversion control block
`include "acc_map.svh"

package acc_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_ARMED,
        SEQ_START,
        SEQ_BUSY
    } acc_seq_state_t;

    // whole state of the sequencer
    typedef struct packed {
        acc_seq_state_t st;
        logic           trig_d;
        logic           start;
        logic           abort;
        logic           power;
    } acc_seq_t;

    // all-ones channel code switches the converter off
    function automatic logic acc_chan_off(input logic [4:0] ch);
        acc_chan_off = (ch == `ACC_CHAN_OFF);
    endfunction

endpackage

// ### core/acc_conv_seq.sv
// conversion sequencer: single, continuous, software and hardware triggered
`timescale 1ns/1ps

module acc_conv_seq (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    input  wire logic       sc_write,
    input  wire logic       hw_mode,
    input  wire logic       cont,
    input  wire logic [4:0] chan_code,
    input  wire logic       hw_trigger,
    input  wire logic       conv_done,
    output logic            conv_start,
    output logic            conv_abort,
    output logic            conv_power,
    output logic            done_ok
);

    acc_pkg::acc_seq_t s;
    acc_pkg::acc_seq_t next_s;
    logic              trig_rise;

    // ----
    // next state
    // ----
    // a trigger counts on its rising edge only, so a held level starts one conversion
    assign trig_rise = hw_trigger & ~s.trig_d;
    assign done_ok   = (s.st == acc_pkg::SEQ_BUSY) & conv_done;

    always_comb begin
        next_s        = s;
        next_s.trig_d = hw_trigger;
        next_s.start  = 1'b0;
        next_s.abort  = 1'b0;
        case (s.st)
            acc_pkg::SEQ_IDLE: begin
                next_s.st = acc_pkg::SEQ_IDLE;
            end
            acc_pkg::SEQ_ARMED: begin
                if (trig_rise) begin
                    next_s.st = acc_pkg::SEQ_START;                 // [R5] [R6]
                end
            end
            acc_pkg::SEQ_START: begin
                next_s.start = 1'b1;
                next_s.st    = acc_pkg::SEQ_BUSY;
            end
            acc_pkg::SEQ_BUSY: begin
                if (conv_done) begin
                    if (cont) begin
                        next_s.st = acc_pkg::SEQ_START;             // [R6]
                    end else if (hw_mode) begin
                        next_s.st = acc_pkg::SEQ_ARMED;             // [R5]
                    end else begin
                        next_s.st = acc_pkg::SEQ_IDLE;              // [R5] [R11]
                    end
                end
            end
            default: begin
                next_s.st = acc_pkg::SEQ_IDLE;
            end
        endcase
        // a status/control write restarts everything with the new settings
        if (sc_write) begin
            next_s.abort = (s.st == acc_pkg::SEQ_BUSY) & ~conv_done;  // [R15]
            next_s.start = 1'b0;                                    // stale start dropped
            if (acc_pkg::acc_chan_off(chan_code)) begin
                next_s.st = acc_pkg::SEQ_IDLE;                      // [R9] [R10]
            end else if (hw_mode) begin
                next_s.st = acc_pkg::SEQ_ARMED;
            end else begin
                next_s.st = acc_pkg::SEQ_START;                     // [R5] [R6] [R15]
            end
        end
        // power only while a conversion is pending or running
        next_s.power = (next_s.st == acc_pkg::SEQ_START) |
                       (next_s.st == acc_pkg::SEQ_BUSY);            // [R11]
    end

    // ----
    // state register
    // ----
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s <= '{acc_pkg::SEQ_IDLE, 1'b0, 1'b0, 1'b0, 1'b0};
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign conv_start = s.start;
    assign conv_abort = s.abort;
    assign conv_power = s.power;

endmodule

// ### test/acc_core_model.sv
// behavioural converter core: answers each start with a done pulse after a set latency unless an abort comes first
`timescale 1ns/1ps

module acc_core_model #(
    parameter logic [9:0] RESULT = 10'h2a5
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       conv_start,
    input  wire logic       conv_abort,
    input  wire logic [7:0] lat,
    output logic            conv_done,
    output logic [9:0]      conv_data
);
    logic [7:0] cnt;

    // ----
    // conversion timer
    // ----
    // data toggles outside the done pulse so a stale result never looks valid
    always_ff @(posedge sys_clk) begin
        conv_done <= 1'h0;
        conv_data <= ~conv_data;
        if (!rst_b) begin
            cnt       <= 8'h00;
            conv_data <= 10'h155;
        end else if (conv_start) begin
            cnt <= lat;
        end else if (conv_abort) begin
            cnt <= 8'h00;
        end else if (cnt == 8'h01) begin
            cnt       <= 8'h00;
            conv_done <= 1'h1;
            conv_data <= RESULT;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule

// ### test/acc_ctrl_sva.sv
// port-level checks of the conversion control block
`timescale 1ns/1ps

module acc_ctrl_sva (
    input wire logic       sys_clk, rst_b, s_axi_awvalid, s_axi_awready,
    input wire logic       s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
    input wire logic       s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic       conv_start, conv_power, channel_valid, channel_isolate,
    input wire logic [4:0] channel_select
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // ----
    // bus and converter relations
    // ----
    // both write halves taken at one edge
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // readies drop for a cycle, then the response shows
    sequence wr_answer;
        !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
    endsequence

    write_resp_a: assert property (wr_taken |=> wr_answer) else $error("write answer late");
    bresp_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    start_pulse_a: assert property (conv_start |=> !conv_start) else $error("start too long");
    start_power_a: assert property (conv_start |-> conv_power) else $error("start unpowered");
    off_no_start_a: assert property (channel_isolate |-> !conv_start) else $error("start when off");
    off_code_a: assert property (channel_isolate == (channel_select == 5'h1f))
        else $error("isolate mismatch");
    valid_code_a: assert property (channel_valid == !channel_select[3])
        else $error("channel decode mismatch");
endmodule

bind acc_ctrl acc_ctrl_sva chk_u (.sys_clk, .rst_b, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .conv_start, .conv_power, .channel_valid,
    .channel_isolate, .channel_select);

// ### test/acc_ctrl_tb.sv
// self-checking bench of the conversion control block
`timescale 1ns/1ps

module acc_ctrl_tb;
    typedef struct {logic [7:0] a; logic [31:0] d, q; logic [1:0] r;} acc_row_t;
    logic        sys_clk = 1'h0, rst_b = 1'h0, hw_conversion_trigger = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lat = 8'h05;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs, conv_clock_source_select;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        conv_done, conv_start, conv_abort, conv_power, channel_valid;
    logic        channel_isolate, irq;
    logic [4:0]  channel_select, c;
    logic [7:0]  analog_pin_disable_n;
    logic [9:0]  conv_data;
    int          miscompares = 0, checks = 0, starts = 0, aborts = 0, n0, a0;
    logic [4:0]  codes [6] = '{5'h00, 5'h07, 5'h08, 5'h10, 5'h17, 5'h1f};
    acc_row_t    rows [7] = '{'{8'h04, 32'h1, 32'h1, 2'h0}, '{8'h04, 32'h2, 32'h2, 2'h0},
        '{8'h04, 32'h3, 32'h3, 2'h0}, '{8'h04, 32'h0, 32'h0, 2'h0},
        '{8'h14, 32'ha5, 32'ha5, 2'h0}, '{8'h14, 32'h5a, 32'h5a, 2'h0},
        '{8'h20, 32'hff, 32'h0, 2'h2}};

    acc_ctrl dut_u (.sys_clk, .rst_b, .ce(1'h1), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'h1), .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'h1),
        .hw_conversion_trigger, .conv_done, .conv_data, .conv_start, .conv_abort,
        .conv_power, .channel_select, .channel_valid, .channel_isolate,
        .conv_clock_source_select, .analog_pin_disable_n, .irq);
    acc_core_model core_u (.sys_clk, .rst_b, .conv_start, .conv_abort, .lat, .conv_done,
        .conv_data);

    // ----
    // helpers
    // ----
    always #2.5 sys_clk = ~sys_clk;
    // pulse counters; ready lines stay high so no wait is ever needed on them
    always @(posedge sys_clk) begin
        starts += (conv_start === 1'h1);
        aborts += (conv_abort === 1'h1);
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error: %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'h0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic complete_run();
        if (miscompares == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ----
    // sequence
    // ----
    // a hang shows up as one extra mismatch
    initial begin
        #50000;
        miscompares++;
        complete_run();
    end
    initial begin
        tick(4);
        rst_b <= 1'h1;
        tick(1);
        rd(8'h14, v, rs);
        chk("pins reset", v, 32'h0);
        chk("off at reset", channel_isolate, 1'h1);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, rs);
            chk("bresp", rs, rows[i].r);
            rd(rows[i].a, v, rs);
            chk("rdata", v, rows[i].q);
            chk("rresp", rs, rows[i].r);
            if (rows[i].a == 8'h04) chk("clock select", conv_clock_source_select, rows[i].d);
            if (rows[i].a == 8'h14) chk("pin disable", analog_pin_disable_n, rows[i].d);
        end
        foreach (codes[i]) begin
            c = codes[i];
            wr(8'h00, {27'h0, c}, rs);
            tick(1);
            chk("channel", channel_select, c);
            chk("valid", channel_valid, (c <= 5'h07) || (c >= 5'h10 && c <= 5'h17));
            chk("isolate", channel_isolate, c == 5'h1f);
            tick(20);
        end
        // single software conversion, interrupt masked then unmasked then cleared
        wr(8'h18, 32'h3, rs);
        n0 = starts;
        wr(8'h00, 32'h43, rs);
        tick(30);
        chk("one start", starts - n0, 1);
        chk("power down", conv_power, 1'h0);
        chk("irq masked", irq, 1'h0);
        rd(8'h00, v, rs);
        chk("done set", v[7], 1'h1);
        wr(8'h1c, 32'h1, rs);
        chk("irq", irq, 1'h1);
        rd(8'h10, v, rs);
        chk("low byte", v, 32'ha5);
        rd(8'h00, v, rs);
        chk("read clears", v[7], 1'h0);
        wr(8'h18, 32'h1, rs);
        chk("irq cleared", irq, 1'h0);
        // compare gate: result 2a5 fails below ff, passes at or above
        wr(8'h08, 32'hff, rs);
        for (int g = 0; g < 2; g++) begin
            wr(8'h04, 32'h08 | (g << 4), rs);
            wr(8'h00, 32'h02, rs);
            tick(30);
            rd(8'h00, v, rs);
            chk("compare", v[7], g[0]);
        end
        wr(8'h04, 32'h0, rs);
        wr(8'h00, 32'h1f, rs);
        rd(8'h00, v, rs);
        chk("write clears", v[7], 1'h0);
        // rewrite during a long conversion restarts it, off code stops it
        lat <= 8'd40;
        n0 = starts;
        a0 = aborts;
        wr(8'h00, 32'h02, rs);
        tick(4);
        wr(8'h00, 32'h03, rs);
        tick(4);
        chk("restart", starts - n0, 2);
        wr(8'h00, 32'h1f, rs);
        tick(4);
        chk("aborts", aborts - a0, 2);
        chk("off power", conv_power, 1'h0);
        lat <= 8'd5;
        // continuous run, then stop with the off code
        n0 = starts;
        wr(8'h00, 32'h21, rs);
        tick(40);
        chk("continuous", starts - n0 > 2, 1'h1);
        wr(8'h00, 32'h1f, rs);
        n0 = starts;
        tick(30);
        chk("no extra", starts - n0, 0);
        // hardware trigger: a write only arms, each rising edge converts once
        wr(8'h04, 32'h04, rs);
        n0 = starts;
        wr(8'h00, 32'h05, rs);
        tick(10);
        chk("armed only", starts - n0, 0);
        repeat (2) begin
            hw_conversion_trigger <= 1'h1;
            tick(2);
            hw_conversion_trigger <= 1'h0;
            tick(20);
        end
        chk("per trigger", starts - n0, 2);
        complete_run();
    end
endmodule
